// file: logic/dacwl_latch.sv
// Converter latch: control bits and code taken from a finished word
`timescale 1ns/1ps
`default_nettype none
module dacwl_latch
	import dacwl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Word from the loader
	dacwl_word_if.dst        wi,
	// Latched outputs
	output var  logic [11:0] dac_code,
	output var  logic        settling_speed_select,
	output var  logic        power_down_select,
	output var  logic        amp_enable,
	output var  logic        update_pulse
);

	// Latch update; reset gives slow mode, powered up, code zero
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dac_code              <= CODE_RST;
			settling_speed_select <= 1'b0;
			power_down_select     <= 1'b0;
			amp_enable            <= 1'b1;
			update_pulse          <= 1'b0;
		end else begin
			update_pulse <= wi.load;
			if (wi.load) begin
				// Bits 15 and 12 are don't-care and never stored
				dac_code              <= wi.word[CODE_MSB:0];
				settling_speed_select <= wi.word[SPD_BIT];
				power_down_select     <= wi.word[PWR_BIT];
				amp_enable            <= ~wi.word[PWR_BIT];
			end
		end
	end

endmodule // dacwl_latch
`default_nettype wire

// file: logic/dacwl_pkg.sv
// Shared constants and types for the serial converter word loader
// Functional notes
// - Chip select low enables serial input
// - Frame-sync fall starts word, MSB-first shifting
// - Load latch after sixteen bits or frame-sync rise
// - Power-on clears control and code latches
// - Own chip select addresses one shared device
// - Full word loads on next rising clock
// - Top four control bits, low twelve code
// - Bit fourteen high selects fast settling
// - Bit thirteen high selects power-down
// - Power-down disables every amplifier
// - One word write sets everything
`default_nettype none
package dacwl_pkg;

	// Word layout
	localparam int unsigned WORD_W   = 16;
	localparam int unsigned CODE_W   = 12;
	localparam int unsigned SPD_BIT  = 14;
	localparam int unsigned PWR_BIT  = 13;
	localparam int unsigned CODE_MSB = 11;

	// Bit counter
	localparam int unsigned CNT_W    = 5;
	localparam logic [4:0]  CNT_ZERO = 5'h00;
	localparam logic [4:0]  CNT_ONE  = 5'h01;
	localparam logic [4:0]  CNT_LAST = 5'h0F;
	localparam logic [4:0]  CNT_FULL = 5'h10;

	// Synchroniser: {cs_n, frame_sync, sclk, sdin}
	localparam int unsigned SYNC_W   = 4;
	localparam logic [3:0]  SYNC_RST = 4'hE;

	// Reset values of the latches and shift register
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [11:0] CODE_RST = 12'h000;

	// Loader states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SHIFT = 3'h2,
		ST_FULL  = 3'h4
	} dacwl_state_t;

endpackage
`default_nettype wire

// file: logic/dacwl_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dacwl_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	// Asynchronous pins in, synchronised levels out
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] sync_out
);

	logic [W-1:0] stage1_r;  // Metastability catcher, read only by stage 2

	// Both stages reset to the idle levels of the pins
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			stage1_r <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			stage1_r <= pin_in;
			sync_out <= stage1_r;
		end
	end

endmodule // dacwl_sync
`default_nettype wire

// file: logic/dacwl_top.sv
// Serial word loader: samples the host link and fills the converter latch
`timescale 1ns/1ps
`default_nettype none
module dacwl_top
	import dacwl_pkg::*;
(
	// System clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Host serial link pins
	input  wire logic        cs_n,
	input  wire logic        frame_sync,
	input  wire logic        sclk,
	input  wire logic        sdin,
	// Converter side
	output var  logic [11:0] dac_code,
	output var  logic        settling_speed_select,
	output var  logic        power_down_select,
	output var  logic        amp_enable,
	output var  logic        update_pulse
);

	// Synchronised pin levels
	logic [3:0]   pins_s;
	wire          cs_n_s = pins_s[3];
	wire          fs_s   = pins_s[2];
	wire          sclk_s = pins_s[1];
	wire          din_s  = pins_s[0];

	// Delayed copies for edge finding
	logic         fs_d_r;
	logic         sclk_d_r;
	logic         din_d_r;

	// Loader state
	dacwl_state_t state_r;
	dacwl_state_t state_nxt;
	logic [4:0]   cnt_r;
	logic [4:0]   cnt_nxt;
	logic [15:0]  shreg_r;
	logic [15:0]  shreg_nxt;

	// Word hand-off to the latch
	dacwl_word_if wif ();

	// All four pins come from the host's domain
	dacwl_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.pin_in   ({cs_n, frame_sync, sclk, sdin}),
		.sync_out (pins_s)
	);

	// Edge history; the data copy lags so the bit is the pre-fall level
	// Reset levels match the idle pins, so no false edge follows reset
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fs_d_r   <= SYNC_RST[2];
			sclk_d_r <= SYNC_RST[1];
			din_d_r  <= SYNC_RST[0];
		end else begin
			fs_d_r   <= fs_s;
			sclk_d_r <= sclk_s;
			din_d_r  <= din_s;
		end
	end

	// Link decode
	wire cs_lo     = ~cs_n_s;
	wire fs_fall   = fs_d_r & ~fs_s;
	wire fs_rise   = ~fs_d_r & fs_s;
	wire sclk_fall = sclk_d_r & ~sclk_s;
	wire sclk_rise = ~sclk_d_r & sclk_s;
	wire in_idle   = (state_r == ST_IDLE);
	wire in_shift  = (state_r == ST_SHIFT);
	wire in_full   = (state_r == ST_FULL);
	// Room is left until the sixteenth bit has gone in
	wire room      = (cnt_r < CNT_FULL);

	// A bit is taken on a clock fall inside a word, or on the fall that
	// coincides with the frame-sync fall, since the host may place them
	// within one sample of each other
	wire shift_en  = cs_lo & sclk_fall &
	                 ((in_shift & room) | (in_idle & fs_fall));

	// Early end on frame-sync rise, or the rise after a full word
	// Both rising together still give one load, never two
	wire load_fs   = cs_lo & fs_rise & (in_shift | in_full);
	wire load_clk  = cs_lo & in_full & sclk_rise & ~fs_rise;
	wire load      = load_fs | load_clk;

	// Shift in MSB first; held while deselected
	assign shreg_nxt = shift_en ? {shreg_r[14:0], din_d_r}
	                            : shreg_r;

	// Next state and bit count
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		if (!cs_lo) begin
			// Deselected: drop any part word, keep shifter and latch
			state_nxt = ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					// Chip select may be tied low; only frame sync starts
					if (fs_fall) begin
						state_nxt = ST_SHIFT;
						cnt_nxt   = shift_en ? CNT_ONE : CNT_ZERO;
					end
				end
				ST_SHIFT: begin
					// Byte hosts leave frame sync low across both bytes,
					// so the count runs on between them
					if (fs_rise) begin
						state_nxt = ST_IDLE;
					end else if (shift_en) begin
						cnt_nxt = cnt_r + CNT_ONE;
						if (cnt_r == CNT_LAST) begin
							state_nxt = ST_FULL;
						end
					end
				end
				ST_FULL: begin
					// Further clock falls are ignored until the load
					if (load) begin
						state_nxt = ST_IDLE;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	// Loader registers
	// Shifter is not cleared at word start, so short words keep old bits
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			cnt_r   <= CNT_ZERO;
			shreg_r <= WORD_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			shreg_r <= shreg_nxt;
		end
	end

	// Word hand-off; no set-up word is needed before the first load
	assign wif.load = load;
	assign wif.word = shreg_r;

	// Converter latch
	dacwl_latch u_latch (
		.clk_sys               (clk_sys),
		.rstn                  (rstn),
		.wi                    (wif.dst),
		.dac_code              (dac_code),
		.settling_speed_select (settling_speed_select),
		.power_down_select     (power_down_select),
		.amp_enable            (amp_enable),
		.update_pulse          (update_pulse)
	);

	// Sequences of the word life cycle
	sequence s_start;
		in_idle && cs_lo && fs_fall;
	endsequence

	sequence s_last_bit;
		in_shift && cs_lo && !fs_rise && shift_en && cnt_r == CNT_LAST;
	endsequence

	sequence s_idle_quiet;
		in_idle && cs_lo && !fs_fall;
	endsequence

	// Deselect returns to idle and loads nothing
	property p_cs_idle;
		@(posedge clk_sys) disable iff (!rstn)
		!cs_lo |-> !load ##1 in_idle;
	endproperty
	a_cs_idle: assert property (p_cs_idle)
		else $error("loader active while deselected");

	// Frame-sync fall opens a word with an empty or one-bit count
	property p_start;
		@(posedge clk_sys) disable iff (!rstn)
		s_start |=> in_shift && cnt_r <= CNT_ONE;
	endproperty
	a_start: assert property (p_start)
		else $error("word not opened on frame sync fall");

	// Each taken bit enters at the bottom, MSB first
	property p_shift;
		@(posedge clk_sys) disable iff (!rstn)
		shift_en |=> shreg_r == {$past(shreg_r[14:0]), $past(din_d_r)};
	endproperty
	a_shift: assert property (p_shift)
		else $error("shift register did not take the bit");

	// The sixteenth bit fills the word
	property p_full;
		@(posedge clk_sys) disable iff (!rstn)
		s_last_bit |=> in_full && cnt_r == CNT_FULL;
	endproperty
	a_full: assert property (p_full)
		else $error("word not full after sixteen bits");

	// Frame-sync rise mid-word loads at once
	property p_fs_load;
		@(posedge clk_sys) disable iff (!rstn)
		cs_lo && fs_rise && (in_shift || in_full) |-> load ##1 in_idle;
	endproperty
	a_fs_load: assert property (p_fs_load)
		else $error("frame sync rise did not load");

	// A full word loads on the next clock rise and reaches the code
	property p_rise_load;
		@(posedge clk_sys) disable iff (!rstn)
		in_full && cs_lo && sclk_rise |-> load
			##1 dac_code == $past(shreg_r[11:0]) && update_pulse;
	endproperty
	a_rise_load: assert property (p_rise_load)
		else $error("full word not loaded on clock rise");

	// Code, speed and power-down latches and shifter read zero straight after reset
	property p_reset;
		@(posedge clk_sys) disable iff (!rstn)
		$rose(rstn) |-> dac_code == CODE_RST && !power_down_select
			&& !settling_speed_select && shreg_r == WORD_RST;
	endproperty
	a_reset: assert property (p_reset)
		else $error("latches not cleared by reset");

	// Control bits come from word bits 14 and 13
	property p_ctrl;
		@(posedge clk_sys) disable iff (!rstn)
		load |=> settling_speed_select == $past(shreg_r[14])
			&& power_down_select == $past(shreg_r[13]);
	endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("control bits latched wrongly");

	// Amplifiers follow the power state
	property p_amp;
		@(posedge clk_sys) disable iff (!rstn)
		amp_enable == !power_down_select;
	endproperty
	a_amp: assert property (p_amp)
		else $error("amplifier enable disagrees with power state");

	// Shifter and code hold while deselected
	property p_hold;
		@(posedge clk_sys) disable iff (!rstn)
		!cs_lo && !update_pulse |=> $stable(shreg_r) && $stable(dac_code);
	endproperty
	a_hold: assert property (p_hold)
		else $error("state changed while deselected");

	// Count never runs past a full word
	property p_cnt_cap;
		@(posedge clk_sys) disable iff (!rstn)
		in_full |-> !shift_en && cnt_r == CNT_FULL;
	endproperty
	a_cnt_cap: assert property (p_cnt_cap)
		else $error("bits taken after a full word");

	// Without a frame-sync fall the idle loader takes no bit
	property p_idle_wait;
		@(posedge clk_sys) disable iff (!rstn)
		s_idle_quiet |=> in_idle && $stable(shreg_r);
	endproperty
	a_idle_wait: assert property (p_idle_wait)
		else $error("idle loader moved without a word start");

	// A load hands the low twelve bits to the code and pulses
	property p_code;
		@(posedge clk_sys) disable iff (!rstn)
		load |=> dac_code == $past(shreg_r[11:0]) && update_pulse;
	endproperty
	a_code: assert property (p_code)
		else $error("code latch missed the word");

	// One word gives one load; the loader is idle straight after
	property p_load_once;
		@(posedge clk_sys) disable iff (!rstn)
		load |=> !load && in_idle;
	endproperty
	a_load_once: assert property (p_load_once)
		else $error("word loaded more than once");

	// Latched values stand until the next word loads
	property p_latch_hold;
		@(posedge clk_sys) disable iff (!rstn)
		!load |=> $stable(dac_code) && $stable(settling_speed_select)
			&& $stable(power_down_select) && !update_pulse;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latch changed without a load");

endmodule // dacwl_top
`default_nettype wire

// file: logic/dacwl_word_if.sv
// Carrier of a finished word from the loader to the converter latch
`timescale 1ns/1ps
`default_nettype none
interface dacwl_word_if;
	logic        load;   // One-cycle transfer strobe
	logic [15:0] word;   // Shift register contents

	modport src (output load, output word);
	modport dst (input load, input word);
endinterface
`default_nettype wire

// file: tb/dacwl_host.sv
// Host serial port model driving the converter link pins
`timescale 1ns/1ps
`default_nettype none
module dacwl_host (
	// Word request from the bench
	input  wire logic        req,
	input  wire logic [15:0] word,
	input  wire logic [4:0]  nbits,
	input  wire logic        sel,
	input  wire logic        tw,
	output var  logic        done,
	// Link pins
	output var  logic        cs_n,
	output var  logic        frame_sync,
	output var  logic        sclk,
	output var  logic        sdin
);
	int i; // Bit index

	// Clock stands high between frames; phase kept off the system clock
	initial begin
		done = 1'h0;
		cs_n = 1'h1;
		frame_sync = 1'h1;
		sclk = 1'h1;
		sdin = 1'h0;
		forever begin
			wait (req);
			#3 cs_n = ~sel;
			sdin = word[15];
			#40 frame_sync = 1'h0;
			#40;
			for (i = 0; i < nbits; i++) begin
				sclk = 1'h0;
				#80 sclk = 1'h1;
				// Data moves on the rise, clear of the sampling fall
				sdin = (i < 15) ? word[14 - i] : ~sdin;
				#80;
				// Byte hosts pause with the clock high between bytes
				if (i == 7) #320;
			end
			// Gap keeps the loading clock rise apart from the frame end
			#160 frame_sync = 1'h1;
			// Three-wire hosts leave chip select low
			#80 if (!tw) cs_n = 1'h1;
			sdin = ~sdin; // Released line shows no stale value
			#80 done = 1'h1;
			wait (!req);
			done = 1'h0;
		end
	end
endmodule // dacwl_host
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the serial converter word loader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dacwl_pkg::*;
	logic        clk_sys, rstn, req, sel, tw, done;
	logic        cs_n, frame_sync, sclk, sdin, sclk_q, fs_q;
	logic [15:0] word, exp_sr, lat;
	logic [4:0]  nbits;
	logic [11:0] dac_code;
	logic        settling_speed_select, power_down_select;
	logic        amp_enable, update_pulse;
	int          err_count, checked, cyc, last_evt, pulses, lag, j;
	logic [15:0] dir [6] = '{16'h0000, 16'hFFFF, 16'h4ABC,
		16'h2123, 16'h9001, 16'h6800};

	dacwl_top dacwl_top_i (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n),
		.frame_sync(frame_sync), .sclk(sclk), .sdin(sdin),
		.dac_code(dac_code), .settling_speed_select(settling_speed_select),
		.power_down_select(power_down_select), .amp_enable(amp_enable),
		.update_pulse(update_pulse));
	dacwl_host dacwl_host_i (.req(req), .word(word), .nbits(nbits),
		.sel(sel), .tw(tw), .done(done), .cs_n(cs_n),
		.frame_sync(frame_sync), .sclk(sclk), .sdin(sdin));

	// 50 MHz system clock
	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Latched outputs against the last word expected to load
	task automatic chk_out();
		chk({settling_speed_select, power_down_select, amp_enable, 1'h0,
			dac_code}, {lat[14], lat[13], ~lat[13], 1'h0, lat[11:0]});
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Track link edges, load pulses and their lag; cut a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		sclk_q <= sclk;
		fs_q <= frame_sync;
		if ((sclk & ~sclk_q) | (frame_sync & ~fs_q)) begin
			last_evt <= cyc;
		end
		if (update_pulse === 1'h1) begin
			pulses <= pulses + 1;
			lag = cyc - last_evt;
			chk(16'(lag >= 3 && lag <= 5), 16'h0001);
		end
		if (cyc > 10000) begin
			err_count++;
			stop_test();
		end
	end

	// One word through the host model, then its effect at the ports
	task automatic send(input logic [15:0] w, input logic [4:0] n,
		input logic s, input logic t);
		int p;
		int k;
		p = pulses;
		@(posedge clk_sys);
		word <= w;
		nbits <= n;
		sel <= s;
		tw <= t;
		req <= 1'h1;
		for (k = 0; k < 400 && done !== 1'h1; k++) @(posedge clk_sys);
		// A host that never finishes counts against the run
		chk({15'h0000, done}, 16'h0001);
		req <= 1'h0;
		@(posedge clk_sys);
		while (done === 1'h1) @(posedge clk_sys);
		// Deselected words leave shift register and latch alone
		if (s) begin
			// Clock falls past the sixteenth are refused
			for (k = 0; k < n && k < 16; k++) exp_sr = {exp_sr[14:0], w[15 - k]};
			lat = exp_sr;
		end
		chk(16'(pulses - p), {15'h0000, s});
		chk_out();
	endtask

	initial begin
		rstn = 1'h0;
		req = 1'h0;
		word = 16'h0000;
		nbits = 5'h00;
		sel = 1'h0;
		tw = 1'h0;
		cyc = 0;
		last_evt = 0;
		pulses = 0;
		err_count = 0;
		checked = 0;
		exp_sr = 16'h0000;
		lat = 16'h0000;
		j = $urandom(32'h36ad);
		repeat (10) @(posedge clk_sys);
		rstn <= 1'h1;
		repeat (3) @(posedge clk_sys);
		chk_out();
		// Control bit combinations and ignored bits
		foreach (dir[i]) send(dir[i], 5'h10, 1'h1, 1'h0);
		repeat (8) send(16'($urandom), 5'h10, 1'h1, 1'h0);
		// Early frame end loads a partly shifted register
		send(16'($urandom), 5'h00, 1'h1, 1'h0);
		send(16'($urandom), 5'h05, 1'h1, 1'h0);
		send(16'($urandom), 5'h0F, 1'h1, 1'h0);
		// Extra clock falls after a full word change nothing
		send(16'($urandom), 5'h12, 1'h1, 1'h0);
		// Another device's word on the shared port
		send(16'($urandom), 5'h10, 1'h0, 1'h0);
		send(16'($urandom), 5'h07, 1'h0, 1'h0);
		// Chip select held low, words split by frame sync only
		send(16'($urandom), 5'h10, 1'h1, 1'h1);
		send(16'($urandom), 5'h10, 1'h1, 1'h1);
		send(16'h5A5A, 5'h10, 1'h1, 1'h0);
		// Reset in mid-run clears latch and shift register
		@(posedge clk_sys);
		rstn <= 1'h0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'h1;
		exp_sr = 16'h0000;
		lat = 16'h0000;
		repeat (3) @(posedge clk_sys);
		chk_out();
		send(16'hB3C7, 5'h04, 1'h1, 1'h0);
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
